// *** pkg/pms_pkg.sv ***
// Shared constants, register map and field layout of the supervisory control block.
package pms_pkg;

    // Clock and timing.
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned HOLD_TIME_MS   = 1000;
    localparam int unsigned HOLD_CYCLES    = HOLD_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned REARM_TIME_US  = 32;
    localparam int unsigned REARM_CYCLES   = REARM_TIME_US * CLK_MHZ;

    // Register offsets.
    localparam logic [7:0] ADDR_INPUT_PATH = 8'h01;
    localparam logic [7:0] ADDR_FLAGS      = 8'h02;
    localparam logic [7:0] ADDR_MASK       = 8'h03;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_CHARGER    = 8'h05;

    // Reset values.
    localparam logic [7:0] RST_INPUT_PATH  = 8'h00;
    localparam logic [7:0] RST_MASK        = 8'h00;
    localparam logic       RST_CHARGER_ON  = 1'b0;

    // Field positions in input_path_control.
    localparam int unsigned ADAPTER_DRAIN_LSB = 6;
    localparam int unsigned USB_DRAIN_LSB     = 4;
    localparam logic [1:0]  DRAIN_FORCE_OFF   = 2'h3;

    // Event flag bit positions.
    localparam int unsigned EVT_BUTTON    = 0;
    localparam int unsigned EVT_USB       = 1;
    localparam int unsigned EVT_AC        = 2;
    localparam int unsigned EVT_FAULT_LSB = 3;
    localparam int unsigned FAULT_W       = 4;

    // Comparator input bit positions.
    localparam int unsigned CMP_AC_OVER_4V3    = 0;
    localparam int unsigned CMP_USB_OVER_4V3   = 1;
    localparam int unsigned CMP_AC_OVER_4V1    = 2;
    localparam int unsigned CMP_AC_OVER_UVOFF  = 3;
    localparam int unsigned CMP_USB_OVER_UVOFF = 4;
    localparam int unsigned CMP_AC_OVER_BAT190 = 5;
    localparam int unsigned CMP_AC_OVER_BAT125 = 6;
    localparam int unsigned CMP_USB_OVER_B190  = 7;
    localparam int unsigned CMP_USB_OVER_B125  = 8;
    localparam int unsigned CMP_BAT_OVER_1V5   = 9;
    localparam int unsigned CMP_BAT_OVER_UVLO  = 10;
    localparam int unsigned CMP_BAT_OVER_SC    = 11;
    localparam int unsigned CMP_BAT_OVER_LOWV  = 12;
    localparam int unsigned CMP_BAT_AT_VREG    = 13;
    localparam int unsigned CMP_W              = 14;

    // Charger phase codes.
    typedef enum logic [2:0] {
        CHG_IDLE,
        CHG_SHORT_TEST,
        CHG_PRECHARGE,
        CHG_FAST,
        CHG_CONST_V
    } pms_chg_phase_t;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_POWERUP,
        ST_ACTIVE
    } pms_state_t;

endpackage : pms_pkg

// *** logic/pms_sync.sv ***
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module pms_sync #(
    parameter int unsigned      WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pms_sync_state_t;

    pms_sync_state_t state_reg;
    pms_sync_state_t state_next;

    always_comb begin
        state_next.meta   = async_i;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Reset to the idle level of each pin so that no false edge follows reset.
            state_reg <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stable;

endmodule : pms_sync

// *** logic/pms_charger.sv ***
// Charger start check and phase sequencing.
`timescale 1ns/1ps
module pms_charger
    import pms_pkg::*;
(
    input  wire logic           core_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           enable_i,
    input  wire logic           bat_over_sc_i,
    input  wire logic           bat_over_lowv_i,
    input  wire logic           bat_at_vreg_i,
    output pms_pkg::pms_chg_phase_t phase_o,
    output logic                short_test_o
);
    typedef struct packed {
        pms_chg_phase_t phase;
        logic           short_test;
    } pms_chg_state_t;

    pms_chg_state_t state_reg;
    pms_chg_state_t state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg.phase)
            CHG_IDLE: begin
                if (enable_i) begin
                    state_next.phase = CHG_SHORT_TEST;
                end
            end
            CHG_SHORT_TEST: begin
                if (bat_over_sc_i) begin
                    state_next.phase = CHG_PRECHARGE;
                end
            end
            CHG_PRECHARGE: begin
                if (bat_over_lowv_i) begin
                    state_next.phase = CHG_FAST;
                end
            end
            CHG_FAST: begin
                if (bat_at_vreg_i) begin
                    state_next.phase = CHG_CONST_V;
                end
            end
            CHG_CONST_V: begin
                state_next.phase = CHG_CONST_V;
            end
            default: begin
                state_next.phase = CHG_IDLE;
            end
        endcase
        // Turning the charger off abandons any phase; a fresh start retests the pin.
        if (!enable_i) begin
            state_next.phase = CHG_IDLE;
        end
        state_next.short_test = (state_next.phase == CHG_SHORT_TEST);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '{phase: CHG_IDLE, short_test: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign phase_o      = state_reg.phase;
    assign short_test_o = state_reg.short_test;

endmodule : pms_charger

// *** logic/pms_supervisor.sv ***
// Supervisory restart, event request and power path selection logic.
//
// Behaviour
// - Restart pin low: rails off, registers default.
// - Rails stay off while low, at least 1 s.
// - Restart release enters active, starts power-up.
// - Events set flag and pull request low.
// - Flag read clears flags, releases request pin.
// - Lasting fault re-sets flag within 32 us.
// - Button edges and input status changes raise events.
// - Masks gate only the request pin.
// - Weak battery: valid above 4.3 V, hysteresis.
// - Both inputs valid: draw from AC.
// - Shorted battery: AC below 4.1 V uses USB.
// - Dead battery: AC stays once selected.
// - Good battery: present 190 mV, absent 125 mV.
// - No input or blocked: battery feeds system.
// - AC sink on: USB valid, AC absent.
// - USB sink on: AC valid, USB absent.
// - Both drain fields 11b force sinks off.
// - Charger tests battery short before charging.
// - Charge phases: precharge, fast, constant voltage.
// - Button edges flag; status shows level.
`timescale 1ns/1ps
module pms_supervisor
    import pms_pkg::*;
#(
    parameter int unsigned HOLD_COUNT = pms_pkg::HOLD_CYCLES
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       hard_restart_pin_n_i,
    input  wire logic                       button_input_n_i,
    input  wire logic [pms_pkg::CMP_W-1:0]  cmp_i,
    input  wire logic [pms_pkg::FAULT_W-1:0] fault_i,
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [7:0]                 reg_wdata_i,
    output logic      [7:0]                 reg_rdata_o,
    output logic                            event_request_pin_o,
    output logic                            event_request_pin_oe_o,
    output logic                            rails_on_o,
    output logic                            powerup_start_o,
    output logic                            sel_ac_o,
    output logic                            sel_usb_o,
    output logic                            sel_bat_o,
    output logic                            ac_sink_o,
    output logic                            usb_sink_o,
    output logic                            bat_short_test_o,
    output logic      [2:0]                 charge_phase_o
);
    localparam int unsigned SYNC_W = CMP_W + FAULT_W + 2;
    // The restart and button pins idle high; comparators and faults idle low.
    localparam logic [SYNC_W-1:0] SYNC_RST = {2'b11, {(SYNC_W-2){1'b0}}};

    typedef struct packed {
        pms_state_t  st;
        logic [31:0] hold_cnt;
        logic [7:0]  input_path;
        logic [7:0]  mask;
        logic        charger_on;
        logic [7:0]  flags;
        logic        btn_level;
        logic        ac_valid;
        logic        usb_valid;
        logic        ac_locked;
        logic [7:0]  rdata;
        logic        req_oe;
        logic        rails_on;
        logic        powerup;
        logic        sel_ac;
        logic        sel_usb;
        logic        sel_bat;
        logic        ac_sink;
        logic        usb_sink;
    } pms_core_t;

    pms_core_t            core_reg;
    pms_core_t            core_next;
    logic [SYNC_W-1:0]    sync_q;
    logic [CMP_W-1:0]     cmp_q;
    logic [FAULT_W-1:0]   fault_q;
    logic                 restart_n_q;
    logic                 button_q;
    pms_chg_phase_t       chg_phase;
    logic                 chg_short_test;

    // Every analog result, fault input and the restart and button pins pass the synchroniser before any logic sees them.
    pms_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    ({hard_restart_pin_n_i, button_input_n_i, fault_i, cmp_i}),
        .sync_o     (sync_q)
    );

    assign cmp_q       = sync_q[CMP_W-1:0];
    assign fault_q     = sync_q[CMP_W+FAULT_W-1:CMP_W];
    assign button_q    = sync_q[CMP_W+FAULT_W];
    assign restart_n_q = sync_q[CMP_W+FAULT_W+1];

    pms_charger u_charger (
        .core_clk_i      (core_clk_i),
        .rst_n_i         (rst_n_i),
        .enable_i        (core_reg.charger_on),
        .bat_over_sc_i   (cmp_q[CMP_BAT_OVER_SC]),
        .bat_over_lowv_i (cmp_q[CMP_BAT_OVER_LOWV]),
        .bat_at_vreg_i   (cmp_q[CMP_BAT_AT_VREG]),
        .phase_o         (chg_phase),
        .short_test_o    (chg_short_test)
    );

    // Input validity with hysteresis; thresholds depend on the battery condition.
    function automatic logic input_valid(input logic prev, input logic weak_bat, input logic over_4v3,
                                         input logic over_uvoff, input logic over_190, input logic over_125);
        if (weak_bat) begin
            input_valid = prev ? over_uvoff : over_4v3;
        end else begin
            input_valid = prev ? over_125 : over_190;
        end
    endfunction : input_valid

    always_comb begin
        logic       weak_bat;
        logic       shorted_bat;
        logic       active;
        logic       flag_read;
        logic       force_off;
        logic [7:0] set_bits;
        weak_bat    = !cmp_q[CMP_BAT_OVER_UVLO];
        shorted_bat = !cmp_q[CMP_BAT_OVER_1V5];
        active      = 1'b0;
        force_off   = 1'b0;
        set_bits    = 8'h00;
        flag_read   = reg_rd_i && (reg_addr_i == ADDR_FLAGS);
        core_next   = core_reg;
        core_next.powerup = 1'b0;

        // Restart sequencing.
        unique case (core_reg.st)
            ST_HOLD: begin
                if (core_reg.hold_cnt < HOLD_COUNT) begin
                    core_next.hold_cnt = core_reg.hold_cnt + 32'h1;
                end
                if (restart_n_q && core_reg.hold_cnt >= HOLD_COUNT - 1) begin
                    core_next.st      = ST_POWERUP;
                    core_next.powerup = 1'b1;
                end
            end
            ST_POWERUP: begin
                core_next.st = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                core_next.st = ST_ACTIVE;
            end
            default: begin
                core_next.st = ST_HOLD;
            end
        endcase
        core_next.rails_on = (core_next.st != ST_HOLD);
        active = (core_reg.st == ST_ACTIVE);

        // Register writes.
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_INPUT_PATH: core_next.input_path = reg_wdata_i;
                ADDR_MASK:       core_next.mask       = reg_wdata_i;
                ADDR_CHARGER:    core_next.charger_on = reg_wdata_i[0];
                default:         core_next.charger_on = core_reg.charger_on;
            endcase
        end

        // Input detection and path choice.
        core_next.btn_level = button_q;
        core_next.ac_valid  = input_valid(core_reg.ac_valid, weak_bat, cmp_q[CMP_AC_OVER_4V3],
                                          cmp_q[CMP_AC_OVER_UVOFF], cmp_q[CMP_AC_OVER_BAT190],
                                          cmp_q[CMP_AC_OVER_BAT125]);
        core_next.usb_valid = input_valid(core_reg.usb_valid, weak_bat, cmp_q[CMP_USB_OVER_4V3],
                                          cmp_q[CMP_USB_OVER_UVOFF], cmp_q[CMP_USB_OVER_B190],
                                          cmp_q[CMP_USB_OVER_B125]);
        core_next.sel_ac  = 1'b0;
        core_next.sel_usb = 1'b0;
        core_next.sel_bat = 1'b0;
        if (!active || (!core_reg.ac_valid && !core_reg.usb_valid)) begin
            core_next.sel_bat = 1'b1;
        end else if (core_reg.ac_valid && core_reg.usb_valid) begin
            // A dead battery keeps AC once chosen; a shorted one falls back below 4.1 V.
            if (weak_bat && !cmp_q[CMP_AC_OVER_4V1] && (shorted_bat || !core_reg.ac_locked)) begin
                core_next.sel_usb = 1'b1;
            end else begin
                core_next.sel_ac = 1'b1;
            end
        end else if (core_reg.ac_valid) begin
            core_next.sel_ac = 1'b1;
        end else begin
            core_next.sel_usb = 1'b1;
        end
        core_next.ac_locked = core_reg.ac_valid && (core_reg.ac_locked || core_reg.sel_ac);

        // Discharge sinks.
        force_off = (core_reg.input_path[ADAPTER_DRAIN_LSB +: 2] == DRAIN_FORCE_OFF) &&
                    (core_reg.input_path[USB_DRAIN_LSB +: 2] == DRAIN_FORCE_OFF);
        core_next.ac_sink  = !force_off && core_reg.usb_valid && !core_reg.ac_valid;
        core_next.usb_sink = !force_off && core_reg.ac_valid && !core_reg.usb_valid;

        // Events: a set arriving with the clearing read survives it.
        set_bits[EVT_BUTTON] = (button_q != core_reg.btn_level);
        set_bits[EVT_USB]    = (core_next.usb_valid != core_reg.usb_valid);
        set_bits[EVT_AC]     = (core_next.ac_valid != core_reg.ac_valid);
        set_bits[EVT_FAULT_LSB +: FAULT_W] = fault_q;
        core_next.flags = (flag_read ? 8'h00 : core_reg.flags) | set_bits;

        // Register reads, answered one cycle after the strobe.
        core_next.rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_INPUT_PATH: core_next.rdata = core_reg.input_path;
                ADDR_FLAGS:      core_next.rdata = core_reg.flags;
                ADDR_MASK:       core_next.rdata = core_reg.mask;
                ADDR_STATUS:     core_next.rdata = {core_reg.sel_bat, core_reg.sel_usb, core_reg.sel_ac,
                                                    core_reg.usb_valid, core_reg.ac_valid, 2'h0,
                                                    core_reg.btn_level};
                ADDR_CHARGER:    core_next.rdata = {chg_phase, 4'h0, core_reg.charger_on};
                default:         core_next.rdata = 8'h00;
            endcase
        end

        // The restart pin wins over everything and wipes the programmed state.
        if (!restart_n_q) begin
            core_next.st         = ST_HOLD;
            core_next.hold_cnt   = 32'h0;
            core_next.rails_on   = 1'b0;
            core_next.powerup    = 1'b0;
            core_next.input_path = RST_INPUT_PATH;
            core_next.mask       = RST_MASK;
            core_next.charger_on = RST_CHARGER_ON;
            core_next.flags      = 8'h00;
        end
        core_next.req_oe = |(core_next.flags & ~core_next.mask);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_reg            <= '0;
            core_reg.st         <= ST_HOLD;
            core_reg.input_path <= RST_INPUT_PATH;
            core_reg.mask       <= RST_MASK;
            core_reg.charger_on <= RST_CHARGER_ON;
            core_reg.btn_level  <= 1'b1;
            core_reg.sel_bat    <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    assign reg_rdata_o            = core_reg.rdata;
    assign event_request_pin_o    = 1'b0;
    assign event_request_pin_oe_o = core_reg.req_oe;
    assign rails_on_o             = core_reg.rails_on;
    assign powerup_start_o        = core_reg.powerup;
    assign sel_ac_o               = core_reg.sel_ac;
    assign sel_usb_o              = core_reg.sel_usb;
    assign sel_bat_o              = core_reg.sel_bat;
    assign ac_sink_o              = core_reg.ac_sink;
    assign usb_sink_o             = core_reg.usb_sink;
    assign bat_short_test_o       = chg_short_test;
    assign charge_phase_o         = chg_phase;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_restart_rails_off: assert property (!restart_n_q |=> !rails_on_o)
        else $error("rails on while restart pin low");
    a_restart_clears_mask: assert property (!restart_n_q |=> core_reg.mask == RST_MASK)
        else $error("mask kept through restart");
    a_hold_min_time: assert property ($fell(rails_on_o) |-> !rails_on_o [*8])
        else $error("rails back on too soon");
    a_powerup_enters: assert property (powerup_start_o |-> core_reg.st == ST_POWERUP ##1 core_reg.st == ST_ACTIVE)
        else $error("power-up did not reach active");
    a_fault_pulls_pin: assert property (fault_q[0] && !core_next.mask[EVT_FAULT_LSB] && restart_n_q
                                        |=> event_request_pin_oe_o)
        else $error("fault did not pull request pin");
    a_read_clears_flags: assert property (reg_rd_i && reg_addr_i == ADDR_FLAGS && fault_q == '0 &&
                                          set_none() && restart_n_q |=> core_reg.flags == 8'h00)
        else $error("flag read left flags set");
    a_lasting_fault_rearms: assert property (reg_rd_i && reg_addr_i == ADDR_FLAGS && fault_q[0] && restart_n_q
                                             |-> ##[1:4] core_reg.flags[EVT_FAULT_LSB])
        else $error("lasting fault not re-flagged");
    a_mask_gates_pin: assert property ((core_reg.flags & ~core_reg.mask) == 8'h00 |-> !event_request_pin_oe_o)
        else $error("masked flag drove request pin");
    a_path_exclusive: assert property ($onehot({sel_ac_o, sel_usb_o, sel_bat_o}))
        else $error("power path selection not exclusive");
    a_blocked_uses_bat: assert property (core_reg.st != ST_ACTIVE |=> sel_bat_o)
        else $error("path not battery while blocked");
    a_sink_forced_off: assert property (core_reg.input_path == 8'hF0 |=> !ac_sink_o && !usb_sink_o)
        else $error("sink on while forced off");
    a_charge_after_test: assert property (chg_phase == CHG_PRECHARGE && $changed(chg_phase)
                                          |-> $past(chg_phase) == CHG_SHORT_TEST)
        else $error("charge began without short test");

    c_restart_release: cover property (core_reg.st == ST_HOLD ##1 core_reg.st == ST_POWERUP);
    c_flag_read: cover property (event_request_pin_oe_o ##1 reg_rd_i && reg_addr_i == ADDR_FLAGS);
    c_usb_fallback: cover property (sel_ac_o ##1 sel_usb_o);
    c_const_voltage: cover property (chg_phase == CHG_CONST_V);

    function automatic logic set_none();
        set_none = (button_q == core_reg.btn_level) && (core_next.usb_valid == core_reg.usb_valid) &&
                   (core_next.ac_valid == core_reg.ac_valid);
    endfunction : set_none

endmodule : pms_supervisor

// *** sim/pms_host_model.sv ***
// Host model that reaches the block's registers one byte per strobe.
`timescale 1ns/1ps
module pms_host_model (
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       core_clk_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o
);
    initial begin
        {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = 18'h0;
    end

    // Drain fields are only ever written as 00b or 11b pairs.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b0;
    endtask : wr

    // A flag read is how the host services the request line.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        {reg_addr_o, reg_rd_o} = {a, 1'b1};
        @(posedge core_clk_i);
        #1;
        reg_rd_o = 1'b0;
        d        = reg_rdata_i;
    endtask : rd
endmodule : pms_host_model

// *** sim/pms_supervisor_bench.sv ***
// Self-checking bench for the supervisory control block.
`timescale 1ns/1ps
module pms_supervisor_bench;
    import pms_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam logic [13:0] GOOD = 14'h0600;
    localparam logic [13:0] AC_G = 14'h0060;
    localparam logic [13:0] US_G = 14'h0180;
    localparam logic [13:0] AC_W = 14'h000D;
    localparam logic [13:0] US_W = 14'h0012;
    logic             clk, rst_n, rst_pin_n, btn_n, wr, rd, oe, pd, rails, pup;
    logic             s_ac, s_usb, s_bat, k_ac, k_usb, sct;
    logic [CMP_W-1:0] cmp;
    logic [3:0]       fault;
    logic [7:0]       addr, wdata, rdata, d;
    logic [2:0]       phase;
    int               fail_count = 0;
    int               tests_run = 0;
    int               n;
    int               off_run = 0;
    wire              irq_line = oe ? pd : 1'b1;

    pms_supervisor #(.HOLD_COUNT(HOLD)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .hard_restart_pin_n_i(rst_pin_n),
        .button_input_n_i(btn_n), .cmp_i(cmp), .fault_i(fault), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .event_request_pin_o(pd),
        .event_request_pin_oe_o(oe), .rails_on_o(rails), .powerup_start_o(pup), .sel_ac_o(s_ac),
        .sel_usb_o(s_usb), .sel_bat_o(s_bat), .ac_sink_o(k_ac), .usb_sink_o(k_usb),
        .bat_short_test_o(sct), .charge_phase_o(phase));
    pms_host_model host_u (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_wdata_o(wdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Length of the current rails-off stretch, in clock edges.
    always @(posedge clk) off_run <= rails ? 0 : off_run + 1;

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    // Path settles through the synchroniser, so allow a few cycles.
    task automatic path(input logic [13:0] c, input logic [4:0] e);
        cmp = c;
        tick(8);
        chk({3'h0, s_ac, s_usb, s_bat, k_ac, k_usb}, {3'h0, e});
    endtask : path

    task automatic wait_up();
        for (n = 0; n < 60 && pup !== 1'b1; n++) tick(1);
        chk(8'(off_run >= HOLD), 8'h01);
        chk(8'(rails), 8'h01);
    endtask : wait_up

    initial begin
        {rst_n, rst_pin_n, btn_n, cmp, fault} = {3'b011, 18'h0};
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        host_u.rd(ADDR_INPUT_PATH, d);
        chk(d, RST_INPUT_PATH);
        host_u.rd(ADDR_MASK, d);
        chk(d, RST_MASK);
        chk({7'h0, rails}, 8'h00);
        wait_up();
        $display("test reset done");
        fault = 4'h1;
        tick(5);
        chk(8'(irq_line), 8'h00);
        host_u.rd(ADDR_FLAGS, d);
        chk(d, 8'h08);
        tick(2);
        chk(8'(irq_line), 8'h00);
        host_u.wr(ADDR_MASK, 8'h08);
        tick(2);
        chk(8'(irq_line), 8'h01);
        host_u.rd(ADDR_FLAGS, d);
        chk(d, 8'h08);
        fault = 4'h0;
        tick(5);
        host_u.rd(ADDR_FLAGS, d);
        host_u.rd(ADDR_FLAGS, d);
        chk(d, 8'h00);
        host_u.wr(ADDR_MASK, 8'h00);
        tick(2);
        chk(8'(irq_line), 8'h01);
        for (int i = 0; i < 2; i++) begin
            btn_n = ~btn_n;
            tick(5);
            chk(8'(irq_line), 8'h00);
            host_u.rd(ADDR_FLAGS, d);
            chk(d, 8'h01);
            host_u.rd(ADDR_STATUS, d);
            chk(d, {7'h40, btn_n});
        end
        $display("test events done");
        path(GOOD | AC_G, 5'b10001);
        path(GOOD | AC_G | US_G, 5'b10000);
        path(GOOD | US_G, 5'b01010);
        host_u.wr(ADDR_INPUT_PATH, 8'hF0);
        path(GOOD | US_G, 5'b01000);
        path(GOOD, 5'b00100);
        path(AC_W | US_W, 5'b10000);
        path(14'h0008 | US_W, 5'b01000);
        path(14'h0000, 5'b00100);
        path(14'h0200 | AC_W | US_W, 5'b10000);
        path(14'h0208 | US_W, 5'b10000);
        $display("test path done");
        host_u.wr(ADDR_CHARGER, 8'h01);
        tick(4);
        chk({4'h0, phase, sct}, 8'h03);
        for (int k = 1; k < 4; k++) begin
            cmp[CMP_BAT_OVER_SC + k - 1] = 1'b1;
            tick(4);
            chk({4'h0, phase, sct}, 8'(2 * (k + 1)));
        end
        host_u.rd(ADDR_CHARGER, d);
        chk(d, 8'h81);
        $display("test charger done");
        rst_pin_n = 1'b0;
        tick(5);
        chk(8'(rails), 8'h00);
        host_u.rd(ADDR_CHARGER, d);
        chk(d, 8'h00);
        host_u.rd(ADDR_INPUT_PATH, d);
        chk(d, RST_INPUT_PATH);
        // A short pulse, so only the hold count can keep the rails off long enough.
        rst_pin_n = 1'b1;
        tick(5);
        chk(8'(rails), 8'h00);
        wait_up();
        $display("test restart done");
        final_report();
    end

    // The run needs about 220 cycles; this limit only cuts a hang.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule : pms_supervisor_bench
